// file: pmp_core.sv
// motor profile settings: command handling behind an apb register map
// Function
// - option absent: modulation status reads zero, error
// - motor command or query forces modulation off
// - profile recalculated only when modulation switched on
// - mode is sensor or count slowdown only
// - mode write with option absent: error, ignored
// - mode read; absent gives absent reply, error
// - frequencies clamped 10 mHz..100 kHz, error
// - frequencies: five digits, 10 mHz step, rounded
// - start above peak: error, both kept
// - negative parameter: error, value ignored
// - profile change corrects pulse counts, posts error
// - frequency query returns start then peak
// - absent: frequency and ramp reads give sentinel
// - ramp times: three digits, 1 ms step
// - ramp write with option absent: error, ignored
// - ramp reads return stored time
// - slowdown count accepted in count mode only
// - pulse counts 1..16777216, profile sets floor
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module pmp_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        option_installed,
  output logic             modulation_enable,
  output logic             motor_profile_mode,
  output logic [23:0]      act_start_freq,
  output logic [23:0]      act_peak_freq,
  output logic [15:0]      act_ramp_up_time,
  output logic [15:0]      act_ramp_down_time,
  output logic [24:0]      act_slowdown_count,
  output logic [24:0]      act_stop_count,
  output logic             exec_error
);

  // all state of the core
  typedef struct packed {
    logic                mod_en;    // modulation on
    logic                mode;      // profile mode
    logic [23:0]         f_start;   // stored start frequency
    logic [23:0]         f_peak;    // stored peak frequency
    logic [23:0]         f_stage;   // start waiting for its peak
    logic                staged;    // start value present
    logic [15:0]         t_up;      // ramp up, ms
    logic [15:0]         t_down;    // ramp down, ms
    logic [24:0]         slow_cnt;  // slowdown pulse count
    logic [24:0]         stop_cnt;  // stop pulse count
    logic [23:0]         a_start;   // active profile snapshot
    logic [23:0]         a_peak;
    logic [15:0]         a_up;
    logic [15:0]         a_down;
    logic [24:0]         a_slow;
    logic [24:0]         a_stop;
    logic                loaded;    // snapshot taken at least once
    logic                err;       // sticky execution error
    logic                err_pls;   // error posted last cycle
    pmp_pkg::pmp_state_t st;        // sequencer
  } pmp_core_st_t;

  pmp_core_st_t s_r;    // state
  pmp_core_st_t s_nxt;  // next state

  pmp_reg_if rif ();    // register access carrier

  logic [24:0] slow_min;  // floor of slowdown count
  logic [24:0] stop_min;  // floor of stop count
  logic        absent;    // option not fitted
  logic        motor_acc; // access to a motor subcommand register
  logic        post;      // an execution error is posted this cycle
  logic [31:0] wv;        // write value
  logic        neg;       // write value negative
  logic [23:0] fu;        // converted frequency
  logic [15:0] tm;        // converted time
  logic [24:0] cv;        // count write value, clamped

  // bus front end
  pmp_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (rif)
  );

  // count floors from the stored profile
  pmp_pulse_limit u_lim (
    .start_freq (s_r.f_start),
    .peak_freq  (s_r.f_peak),
    .up_time    (s_r.t_up),
    .down_time  (s_r.t_down),
    .slow_min   (slow_min),
    .stop_min   (stop_min)
  );

  assign absent             = ~option_installed;
  assign modulation_enable  = s_r.mod_en;
  assign motor_profile_mode = s_r.mode;
  assign act_start_freq     = s_r.a_start;
  assign act_peak_freq      = s_r.a_peak;
  assign act_ramp_up_time   = s_r.a_up;
  assign act_ramp_down_time = s_r.a_down;
  assign act_slowdown_count = s_r.a_slow;
  assign act_stop_count     = s_r.a_stop;
  assign exec_error         = s_r.err_pls;

  // read mux and address decode
  always_comb
  begin
    rif.hit   = 1'b1;
    rif.rdata = 32'h0000_0000;
    unique case (rif.addr)
      pmp_pkg::MOD_CTRL_OFS:
        rif.rdata[pmp_pkg::MOD_EN_BIT] = s_r.mod_en & ~absent;
      pmp_pkg::PROF_MODE_OFS:
        rif.rdata[1:0] = absent ? pmp_pkg::MODE_ABSENT
                                : {1'b0, s_r.mode};
      pmp_pkg::FREQ_START_OFS:
        rif.rdata = absent ? pmp_pkg::SENTINEL
                           : {8'h00, s_r.f_start};
      pmp_pkg::FREQ_PEAK_OFS:
        rif.rdata = absent ? pmp_pkg::SENTINEL
                           : {8'h00, s_r.f_peak};
      pmp_pkg::RAMP_UP_OFS:
        rif.rdata = absent ? pmp_pkg::SENTINEL
                           : {16'h0000, s_r.t_up};
      pmp_pkg::RAMP_DOWN_OFS:
        rif.rdata = absent ? pmp_pkg::SENTINEL
                           : {16'h0000, s_r.t_down};
      pmp_pkg::SLOW_CNT_OFS:
        if (!absent && s_r.mode == pmp_pkg::MODE_COUNT)
          rif.rdata = {7'h00, s_r.slow_cnt};
      pmp_pkg::STOP_CNT_OFS:
        if (!absent)
          rif.rdata = {7'h00, s_r.stop_cnt};
      pmp_pkg::ERR_STAT_OFS:
        rif.rdata[pmp_pkg::ERR_BIT] = s_r.err;
      pmp_pkg::STATUS_OFS:
      begin
        rif.rdata[pmp_pkg::OPT_BIT]    = option_installed;
        rif.rdata[pmp_pkg::LOADED_BIT] = s_r.loaded;
      end
      default:
        rif.hit = 1'b0;
    endcase
  end

  // command execution, correction sequencer and error flag
  always_comb
  begin
    s_nxt     = s_r;
    post      = 1'b0;
    wv        = rif.wdata;
    neg       = wv[pmp_pkg::NEG_BIT];
    fu        = pmp_pkg::freq_units(wv);
    tm        = pmp_pkg::time_ms(wv);
    cv        = 25'h000_0000;
    motor_acc = (rif.wr_stb || rif.rd_stb) &&
                (rif.addr >= pmp_pkg::PROF_MODE_OFS) &&
                (rif.addr <= pmp_pkg::STOP_CNT_OFS);
    // any motor subcommand or query switches modulation off first
    if (motor_acc)
      s_nxt.mod_en = 1'b0;
    // queries that post an error as a side effect
    if (rif.rd_stb)
    begin
      unique case (rif.addr)
        pmp_pkg::MOD_CTRL_OFS,
        pmp_pkg::PROF_MODE_OFS,
        pmp_pkg::FREQ_START_OFS,
        pmp_pkg::FREQ_PEAK_OFS,
        pmp_pkg::RAMP_UP_OFS,
        pmp_pkg::RAMP_DOWN_OFS,
        pmp_pkg::STOP_CNT_OFS:
          post = absent;
        pmp_pkg::SLOW_CNT_OFS:
          post = absent || (s_r.mode != pmp_pkg::MODE_COUNT);
        default:
          post = 1'b0;
      endcase
    end
    // setting commands
    if (rif.wr_stb)
    begin
      unique case (rif.addr)
        pmp_pkg::MOD_CTRL_OFS:
        begin
          if (wv[pmp_pkg::MOD_EN_BIT] && absent)
            post = 1'b1;
          else
            s_nxt.mod_en = wv[pmp_pkg::MOD_EN_BIT];
        end
        pmp_pkg::PROF_MODE_OFS:
        begin
          if (absent)
            post = 1'b1;
          else
            s_nxt.mode = wv[pmp_pkg::MODE_BIT];
        end
        pmp_pkg::FREQ_START_OFS:
        begin
          s_nxt.staged = 1'b0;
          if (absent || neg)
            post = 1'b1;
          else
          begin
            // start waits for the peak so both land together
            s_nxt.f_stage = fu;
            s_nxt.staged  = 1'b1;
            post = pmp_pkg::out_of_span(wv, pmp_pkg::FREQ_MIN_MHZ,
                                        pmp_pkg::FREQ_MAX_MHZ);
          end
        end
        pmp_pkg::FREQ_PEAK_OFS:
        begin
          s_nxt.staged = 1'b0;
          if (absent || neg || !s_r.staged)
            post = 1'b1;
          else
          begin
            post = pmp_pkg::out_of_span(wv, pmp_pkg::FREQ_MIN_MHZ,
                                        pmp_pkg::FREQ_MAX_MHZ);
            if (s_r.f_stage > fu)
              post = 1'b1;
            else
            begin
              s_nxt.f_start = s_r.f_stage;
              s_nxt.f_peak  = fu;
              s_nxt.st      = pmp_pkg::PMP_CORRECT;
            end
          end
        end
        pmp_pkg::RAMP_UP_OFS,
        pmp_pkg::RAMP_DOWN_OFS:
        begin
          if (absent || neg)
            post = 1'b1;
          else
          begin
            post = pmp_pkg::out_of_span(wv, pmp_pkg::TIME_MIN_US,
                                        pmp_pkg::TIME_MAX_US);
            if (rif.addr == pmp_pkg::RAMP_UP_OFS)
              s_nxt.t_up = tm;
            else
              s_nxt.t_down = tm;
            s_nxt.st = pmp_pkg::PMP_CORRECT;
          end
        end
        pmp_pkg::SLOW_CNT_OFS:
        begin
          if (absent || neg || s_r.mode != pmp_pkg::MODE_COUNT)
            post = 1'b1;
          else
          begin
            cv = (wv > {7'h00, pmp_pkg::CNT_MAX}) ? pmp_pkg::CNT_MAX
                                                  : wv[24:0];
            post = (cv < slow_min) || (wv > {7'h00, pmp_pkg::CNT_MAX});
            s_nxt.slow_cnt = (cv < slow_min) ? slow_min : cv;
          end
        end
        pmp_pkg::STOP_CNT_OFS:
        begin
          if (absent || neg)
            post = 1'b1;
          else
          begin
            cv = (wv > {7'h00, pmp_pkg::CNT_MAX}) ? pmp_pkg::CNT_MAX
                                                  : wv[24:0];
            post = (cv < stop_min) || (wv > {7'h00, pmp_pkg::CNT_MAX});
            s_nxt.stop_cnt = (cv < stop_min) ? stop_min : cv;
          end
        end
        default:
          post = post;
      endcase
    end
    // one cycle after a profile change, pull counts up to their floors;
    // no bus strobe can land here since apb needs a setup cycle first
    unique case (s_r.st)
      pmp_pkg::PMP_IDLE:
        s_nxt.st = s_nxt.st;
      pmp_pkg::PMP_CORRECT:
      begin
        s_nxt.st = pmp_pkg::PMP_IDLE;
        if (s_r.slow_cnt < slow_min || s_r.stop_cnt < stop_min)
          post = 1'b1;
        if (s_r.slow_cnt < slow_min)
          s_nxt.slow_cnt = slow_min;
        if (s_r.stop_cnt < stop_min)
          s_nxt.stop_cnt = stop_min;
      end
    endcase
    // profile is recalculated only on switching modulation on
    if (!s_r.mod_en && s_nxt.mod_en)
    begin
      s_nxt.a_start = s_r.f_start;
      s_nxt.a_peak  = s_r.f_peak;
      s_nxt.a_up    = s_r.t_up;
      s_nxt.a_down  = s_r.t_down;
      s_nxt.a_slow  = s_r.slow_cnt;
      s_nxt.a_stop  = s_r.stop_cnt;
      s_nxt.loaded  = 1'b1;
    end
    // sticky flag: read or write-one clears, a new error wins
    if ((rif.rd_stb || (rif.wr_stb && wv[pmp_pkg::ERR_BIT])) &&
        rif.addr == pmp_pkg::ERR_STAT_OFS)
      s_nxt.err = 1'b0;
    if (post)
      s_nxt.err = 1'b1;
    s_nxt.err_pls = post;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.f_start  <= pmp_pkg::START_RST;
      s_r.f_peak   <= pmp_pkg::PEAK_RST;
      s_r.t_up     <= pmp_pkg::TIME_RST;
      s_r.t_down   <= pmp_pkg::TIME_RST;
      s_r.slow_cnt <= pmp_pkg::SLOW_RST;
      s_r.stop_cnt <= pmp_pkg::STOP_RST;
      s_r.st       <= pmp_pkg::PMP_IDLE;
    end
    else
      s_r <= s_nxt;
  end

endmodule : pmp_core

// file: pmp_pkg.sv
// constants, types and helper functions for the motor profile settings block
package pmp_pkg;

  // register byte offsets
  localparam logic [7:0] MOD_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PROF_MODE_OFS  = 8'h04;
  localparam logic [7:0] FREQ_START_OFS = 8'h08;
  localparam logic [7:0] FREQ_PEAK_OFS  = 8'h0C;
  localparam logic [7:0] RAMP_UP_OFS    = 8'h10;
  localparam logic [7:0] RAMP_DOWN_OFS  = 8'h14;
  localparam logic [7:0] SLOW_CNT_OFS   = 8'h18;
  localparam logic [7:0] STOP_CNT_OFS   = 8'h1C;
  localparam logic [7:0] ERR_STAT_OFS   = 8'h20;
  localparam logic [7:0] STATUS_OFS     = 8'h24;

  // field positions
  localparam int MOD_EN_BIT   = 0;
  localparam int MODE_BIT     = 0;
  localparam int ERR_BIT      = 0;
  localparam int OPT_BIT      = 0;
  localparam int LOADED_BIT   = 1;
  localparam int NEG_BIT      = 31;

  // mode encodings and replies
  localparam logic       MODE_SENSOR   = 1'b0;
  localparam logic       MODE_COUNT    = 1'b1;
  localparam logic [1:0] MODE_ABSENT   = 2'h2;
  localparam logic [31:0] SENTINEL     = 32'hFFFF_FFFF;

  // frequency limits: input in mHz, stored in 10 mHz units
  localparam logic [31:0] FREQ_MIN_MHZ = 32'h0000_000A;
  localparam logic [31:0] FREQ_MAX_MHZ = 32'h05F5_E100;
  localparam logic [31:0] FREQ_STEP    = 32'h0000_000A;
  localparam logic [31:0] SIG5_D1      = 32'h0001_86A0;
  localparam logic [31:0] SIG5_D2      = 32'h000F_4240;
  localparam logic [31:0] SIG5_D3      = 32'h0098_9680;

  // ramp time limits: input in us, stored in ms
  localparam logic [31:0] TIME_MIN_US  = 32'h0000_03E8;
  localparam logic [31:0] TIME_MAX_US  = 32'h02AE_A540;
  localparam logic [31:0] TIME_STEP    = 32'h0000_03E8;
  localparam logic [31:0] SIG3_D1      = 32'h0000_03E8;
  localparam logic [31:0] SIG3_D2      = 32'h0000_2710;

  // pulse counts and ramp pulse divisor (10 mHz units times ms, over 2)
  localparam logic [24:0] CNT_MAX      = 25'h100_0000;
  localparam logic [24:0] CNT_MIN      = 25'h000_0001;
  localparam logic [41:0] PULSE_DIV    = 42'h000_0003_0D40;

  // reset values
  localparam logic [23:0] START_RST    = 24'h00_0064;
  localparam logic [23:0] PEAK_RST     = 24'h00_03E8;
  localparam logic [15:0] TIME_RST     = 16'h0064;
  localparam logic [24:0] SLOW_RST     = 25'h000_03E8;
  localparam logic [24:0] STOP_RST     = 25'h000_07D0;

  // command sequencer states
  typedef enum logic [0:0] {PMP_IDLE, PMP_CORRECT} pmp_state_t;

  // round to a multiple of step, half up
  function automatic logic [31:0] round_step(input logic [31:0] v,
                                             input logic [31:0] step);
    round_step = ((v + (step >> 1)) / step) * step;
  endfunction : round_step

  // raw value outside its span
  function automatic logic out_of_span(input logic [31:0] v,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    out_of_span = (v < lo) || (v > hi);
  endfunction : out_of_span

  // mHz to 10 mHz units, clamped, five significant digits
  function automatic logic [23:0] freq_units(input logic [31:0] v);
    logic [31:0] c;
    logic [31:0] u;
    c = (v < FREQ_MIN_MHZ) ? FREQ_MIN_MHZ :
        (v > FREQ_MAX_MHZ) ? FREQ_MAX_MHZ : v;
    u = round_step(c, FREQ_STEP) / FREQ_STEP;
    if (u >= SIG5_D3)
      u = round_step(u, 32'h0000_03E8);
    else if (u >= SIG5_D2)
      u = round_step(u, 32'h0000_0064);
    else if (u >= SIG5_D1)
      u = round_step(u, 32'h0000_000A);
    freq_units = u[23:0];
  endfunction : freq_units

  // us to ms, clamped, three significant digits
  function automatic logic [15:0] time_ms(input logic [31:0] v);
    logic [31:0] c;
    logic [31:0] m;
    c = (v < TIME_MIN_US) ? TIME_MIN_US :
        (v > TIME_MAX_US) ? TIME_MAX_US : v;
    m = round_step(c, TIME_STEP) / TIME_STEP;
    if (m >= SIG3_D2)
      m = round_step(m, 32'h0000_0064);
    else if (m >= SIG3_D1)
      m = round_step(m, 32'h0000_000A);
    time_ms = m[15:0];
  endfunction : time_ms

endpackage : pmp_pkg

// file: pmp_reg_if.sv
// register access carrier between the bus slave and the settings core
`timescale 1ns/1ps
interface pmp_reg_if;
  logic [7:0]  addr;    // byte address of current transfer
  logic [31:0] wdata;   // write data
  logic        wr_stb;  // write takes effect this edge
  logic        rd_stb;  // read side effects take place this edge
  logic [31:0] rdata;   // read value for addr
  logic        hit;     // addr is mapped

  modport bus (output addr, output wdata, output wr_stb, output rd_stb,
               input rdata, input hit);
  modport regs (input addr, input wdata, input wr_stb, input rd_stb,
                output rdata, output hit);
endinterface : pmp_reg_if

// file: pmp_apb_slave.sv
// apb slave front end: zero wait states, registered read data
`timescale 1ns/1ps
module pmp_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  pmp_reg_if.bus           regs
);

  typedef struct packed {
    logic [31:0] prdata;  // read data captured in setup phase
  } pmp_apb_st_t;

  pmp_apb_st_t s_r;   // state
  pmp_apb_st_t s_nxt; // next state

  // strobes toward the core, only in the access phase
  assign regs.addr   = paddr;
  assign regs.wdata  = pwdata;
  assign regs.wr_stb = psel & penable & pwrite;
  assign regs.rd_stb = psel & penable & ~pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~regs.hit;
  assign prdata      = s_r.prdata;

  // capture read data at the setup edge
  always_comb
  begin
    s_nxt = s_r;
    if (psel && !penable && !pwrite)
      s_nxt.prdata = regs.hit ? regs.rdata : 32'h0000_0000;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule : pmp_apb_slave

// file: pmp_pulse_limit.sv
// lower limits of slowdown and stop pulse counts from the stored profile
`timescale 1ns/1ps
module pmp_pulse_limit (
  input  wire logic [23:0] start_freq,
  input  wire logic [23:0] peak_freq,
  input  wire logic [15:0] up_time,
  input  wire logic [15:0] down_time,
  output logic [24:0]      slow_min,
  output logic [24:0]      stop_min
);

  logic [41:0] fsum;  // start plus peak, 10 mHz units
  logic [41:0] up_p;  // pulses spent ramping up, rounded up
  logic [41:0] all_p; // pulses spent on both ramps, rounded up

  // average frequency times ramp time gives the ramp pulse count
  always_comb
  begin
    fsum  = {18'h0_0000, start_freq} + {18'h0_0000, peak_freq};
    up_p  = (fsum * {26'h000_0000, up_time} + pmp_pkg::PULSE_DIV
             - 42'h1) / pmp_pkg::PULSE_DIV;
    all_p = (fsum * ({26'h000_0000, up_time} + {26'h000_0000, down_time})
             + pmp_pkg::PULSE_DIV - 42'h1) / pmp_pkg::PULSE_DIV;
    slow_min = (up_p < 42'h1) ? pmp_pkg::CNT_MIN : up_p[24:0];
    stop_min = (all_p < 42'h1) ? pmp_pkg::CNT_MIN : all_p[24:0];
  end

endmodule : pmp_pulse_limit

// file: pmp_core_sva.sv
// concurrent checks on the settings block ports
`timescale 1ns/1ps
module pmp_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        option_installed,
  input wire logic        modulation_enable,
  input wire logic        motor_profile_mode,
  input wire logic [23:0] act_start_freq,
  input wire logic        exec_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access phase
  logic wr;  // write access
  logic rs;  // read setup
  logic opt; // option fitted
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rs = psel && !penable && !pwrite;
  assign opt = option_installed;
  slverr_access_a: assert property (pslverr |-> acc)
    else $error("slave error outside access");
  mod_absent_a: assert property
    (wr && paddr == pmp_pkg::MOD_CTRL_OFS && !opt |=> !modulation_enable)
    else $error("modulation on without option");
  mod_read_a: assert property
    (rs && paddr == pmp_pkg::MOD_CTRL_OFS && !opt |=> prdata == 0)
    else $error("modulation status not zero");
  mod_off_a: assert property (acc && paddr >= pmp_pkg::PROF_MODE_OFS &&
    paddr <= pmp_pkg::STOP_CNT_OFS |=> !modulation_enable)
    else $error("modulation not forced off");
  act_hold_a: assert property
    (!$rose(modulation_enable) |-> $stable(act_start_freq))
    else $error("active profile changed");
  mode_set_a: assert property (wr && paddr == pmp_pkg::PROF_MODE_OFS
    && opt |=> motor_profile_mode == $past(pwdata[0]))
    else $error("mode not taken");
  mode_keep_a: assert property (wr && paddr == pmp_pkg::PROF_MODE_OFS
    && !opt |=> $stable(motor_profile_mode) ##[0:1] exec_error)
    else $error("mode write absent");
  neg_err_a: assert property (wr && paddr == pmp_pkg::RAMP_UP_OFS
    && pwdata[31] && opt |-> ##[1:2] exec_error)
    else $error("negative value no error");
  sentinel_a: assert property
    (rs && paddr == pmp_pkg::FREQ_START_OFS && !opt |=> prdata == '1)
    else $error("sentinel missing");
  slow_mode_a: assert property (wr && paddr == pmp_pkg::SLOW_CNT_OFS
    && !motor_profile_mode |-> ##[1:2] exec_error)
    else $error("slowdown count in sensor mode");
  cover property (wr && paddr == pmp_pkg::FREQ_PEAK_OFS);
  cover property ($rose(modulation_enable));
  cover property (pslverr);
endmodule : pmp_core_sva
bind pmp_core pmp_core_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .option_installed(option_installed),
  .modulation_enable(modulation_enable),
  .motor_profile_mode(motor_profile_mode),
  .act_start_freq(act_start_freq), .exec_error(exec_error));

// file: pmp_host.sv
// apb host model issuing settings commands and queries
`timescale 1ns/1ps
module pmp_host (
  input wire logic   pclk,
  input wire logic   pready,
  input wire logic   pslverr,
  input wire logic [31:0] prdata,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer, request held until pready is seen high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not keep its value
  endtask : xfer
  // frequency pair: start staged first, peak commits, bare units
  task setfreq(input logic [31:0] s, input logic [31:0] p);
    logic [31:0] q;
    logic e;
    xfer(1'b1, pmp_pkg::FREQ_START_OFS, s, q, e);
    xfer(1'b1, pmp_pkg::FREQ_PEAK_OFS, p, q, e);
  endtask : setfreq
endmodule : pmp_host

// file: pmp_core_tb_top.sv
// self-checking bench for the motor profile settings block
`timescale 1ns/1ps
module pmp_core_tb_top;
  logic pclk, presetn, option_installed, psel, penable, pwrite;
  logic pready, pslverr, mod_on, mode, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] a_start, a_peak;
  int mismatches;
  int compares;
  // bus clock, 8 ns period
  always #4 pclk = ~pclk;
  pmp_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  pmp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_installed(option_installed), .modulation_enable(mod_on),
    .motor_profile_mode(mode), .act_start_freq(a_start),
    .act_peak_freq(a_peak), .act_ramp_up_time(), .act_ramp_down_time(),
    .act_slowdown_count(), .act_stop_count(), .exec_error());
  // compare one value
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // write one register
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr
  // read one register and compare
  task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(n, x, q);
  endtask : rdc
  // let a correction land, then read and clear the sticky flag
  task errc(input logic x);
    repeat (2) @(posedge pclk);
    rdc("err", pmp_pkg::ERR_STAT_OFS, {31'h0000_0000, x});
  endtask : errc
  // rounding, clamping, ordering, negative value
  task t_freq;
    host.setfreq(32'h0000_05E1, 32'h00BC_614E);
    rdc("start", pmp_pkg::FREQ_START_OFS, 32'h0000_0097);
    rdc("peak", pmp_pkg::FREQ_PEAK_OFS, 32'h0012_D6A8);
    errc(1'b0);
    host.setfreq(32'h0000_0005, 32'h0BEB_C200);
    errc(1'b1);
    errc(1'b0);
    rdc("peak", pmp_pkg::FREQ_PEAK_OFS, 32'h0098_9680);
    rdc("stop", pmp_pkg::STOP_CNT_OFS, 32'h0000_2711);
    host.setfreq(32'h0000_4E20, 32'h0000_2710);
    errc(1'b1);
    rdc("start", pmp_pkg::FREQ_START_OFS, 32'h0000_0001);
    wr(pmp_pkg::RAMP_UP_OFS, 32'h8000_03E8);
    errc(1'b1);
    rdc("up", pmp_pkg::RAMP_UP_OFS, 32'h0000_0064);
  endtask : t_freq
  // ramp rounding and clamping, counts raised to the new floor
  task t_ramp;
    wr(pmp_pkg::RAMP_UP_OFS, 32'h00BC_614E);
    errc(1'b1);
    rdc("up", pmp_pkg::RAMP_UP_OFS, 32'h0000_300C);
    rdc("stop", pmp_pkg::STOP_CNT_OFS, 32'h0009_75E1);
    wr(pmp_pkg::RAMP_DOWN_OFS, 32'h02FA_F080);
    errc(1'b1);
    rdc("down", pmp_pkg::RAMP_DOWN_OFS, 32'h0000_AFC8);
  endtask : t_ramp
  // both modes, slowdown count refused in sensor mode, count maximum
  task t_mode;
    wr(pmp_pkg::SLOW_CNT_OFS, 32'h0000_0005);
    errc(1'b1);
    wr(pmp_pkg::PROF_MODE_OFS, 32'h0000_0001);
    rdc("mode", pmp_pkg::PROF_MODE_OFS, 32'h0000_0001);
    rdc("slow", pmp_pkg::SLOW_CNT_OFS, 32'h0009_6259);
    wr(pmp_pkg::SLOW_CNT_OFS, 32'h0100_0001);
    errc(1'b1);
    rdc("slow", pmp_pkg::SLOW_CNT_OFS, 32'h0100_0000);
  endtask : t_mode
  // profile goes live only when modulation turns on
  task t_mod;
    chk("act", 32'h0000_0000, {8'h00, a_start});
    wr(pmp_pkg::MOD_CTRL_OFS, 32'h0000_0001);
    repeat (2) @(negedge pclk);
    chk("act", 32'h0000_0001, {8'h00, a_start});
    chk("act_peak", 32'h0098_9680, {8'h00, a_peak});
    rdc("status", pmp_pkg::STATUS_OFS, 32'h0000_0003);
    rdc("mode", pmp_pkg::PROF_MODE_OFS, 32'h0000_0001);
    @(negedge pclk);
    chk("mod_on", 32'h0000_0000, {31'h0000_0000, mod_on});
  endtask : t_mod
  // option removed: fixed replies, writes refused, unmapped place
  task t_absent;
    @(posedge pclk);
    option_installed <= 1'b0;
    wr(pmp_pkg::MOD_CTRL_OFS, 32'h0000_0001);
    rdc("mod", pmp_pkg::MOD_CTRL_OFS, 32'h0000_0000);
    errc(1'b1);
    rdc("mode", pmp_pkg::PROF_MODE_OFS, 32'h0000_0002);
    wr(pmp_pkg::PROF_MODE_OFS, 32'h0000_0000);
    chk("mode", 32'h0000_0001, {31'h0000_0000, mode});
    rdc("start", pmp_pkg::FREQ_START_OFS, 32'hFFFF_FFFF);
    rdc("down", pmp_pkg::RAMP_DOWN_OFS, 32'hFFFF_FFFF);
    wr(pmp_pkg::RAMP_UP_OFS, 32'h0000_07D0);
    rdc("none", 8'h40, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
    option_installed <= 1'b1;
    rdc("up", pmp_pkg::RAMP_UP_OFS, 32'h0000_300C);
  endtask : t_absent
  // verdict and end of run
  task end_sim;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // reset, then scenarios in turn
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    option_installed = 1'b1;
    mismatches = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_freq;
    t_ramp;
    t_mode;
    t_mod;
    t_absent;
    end_sim;
  end
  // hang guard, well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim;
  end
endmodule : pmp_core_tb_top
